// File: verilog/bus_ctl_pkg.sv
// Constants, state encodings and carrier types of the bus fault, halt and reset control.
package bus_ctl_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam logic [23:0] SSP_VEC_ADDR = 24'h000000;
   localparam logic [23:0] PC_VEC_ADDR = 24'h000004;
   localparam logic [23:0] BUS_FAULT_INPUT_VEC_OFF = 24'h000008;
   localparam logic [23:0] WORD_STEP = 24'h000002;
   localparam logic [31:0] VBR_RESET = 32'h00000000;
   localparam logic [2:0] MASK_RESET = 3'h7;
   localparam logic [2:0] FC_SUPER_DATA = 3'h5;
   localparam logic [4:0] FRAME_LAST = 5'h19;
   localparam int RESET_OUT_CYCLES = 124;
   localparam int EXT_RESET_CYCLES = 10;
   localparam int SYNC_N = 6;
   localparam int IN_ACK = 0;
   localparam int IN_FAULT = 1;
   localparam int IN_HALT = 2;
   localparam int IN_RESET = 3;
   localparam int IN_BREQ = 4;
   localparam int IN_BGACK = 5;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'h0, BUS_ADDR = 3'h1, BUS_WAIT = 3'h3, BUS_GRACE = 3'h2,
      BUS_END = 3'h6, BUS_ABORT = 3'h7, BUS_RERUN = 3'h5
   } bus_state_t;

   typedef enum logic [2:0] {
      SEQ_RST_SSP = 3'h0, SEQ_RST_PC = 3'h1, SEQ_RUN = 3'h3,
      SEQ_STACK = 3'h2, SEQ_VEC = 3'h6, SEQ_DOUBLE = 3'h7
   } seq_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic rmw;
      logic rmw_second;
      logic [2:0] fc;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cycle_req_t;

   typedef struct packed {
      logic done;
      logic bus_error;
      logic [DATA_W-1:0] rdata;
   } cycle_rsp_t;

   typedef struct packed {
      logic [31:0] supervisor_stack_pointer;
      logic [31:0] vbr;
      logic [31:0] pc;
      logic pc_load;
      logic [2:0] int_mask;
      logic resume_at_read;
   } arch_state_t;
endpackage

// File: verilog/bus_fault_halt_reset_control.sv
// Bus cycle termination, bus error exception sequencing, halt and reset control.
`timescale 1ns/1ps
module bus_fault_halt_reset_control #(
   parameter int RESET_OUT_COUNT = bus_ctl_pkg::RESET_OUT_CYCLES,
   parameter int EXT_RESET_COUNT = bus_ctl_pkg::EXT_RESET_CYCLES
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Core cycle requests.
   input wire bus_ctl_pkg::cycle_req_t core_req,
   output logic core_ready,
   output bus_ctl_pkg::cycle_rsp_t core_rsp,
   // Core events and exception frame.
   input wire logic instr_start,
   input wire logic reset_instr,
   input wire logic rte_done,
   output logic [4:0] frame_index,
   input wire logic [15:0] frame_word,
   output bus_ctl_pkg::arch_state_t arch,
   // Bus pins.
   output logic address_strobe_n,
   output logic read_write,
   output logic [2:0] function_code,
   output logic [23:0] address,
   output logic address_oe,
   output logic [15:0] data_out,
   output logic data_oe,
   input wire logic [15:0] data_in,
   input wire logic transfer_acknowledge_n,
   input wire logic bus_fault_input_n,
   // Halt and reset pins.
   input wire logic halt_in_n,
   output logic halt_out_n,
   output logic halt_oe,
   input wire logic reset_in_n,
   output logic reset_out_n,
   output logic reset_oe,
   // Arbitration pins.
   input wire logic bus_request_n,
   input wire logic bus_grant_ack_n,
   output logic bus_grant_n,
   // Abort state indication.
   output logic abort_state_nine,
   output logic rmw_write_abort_state
);
   import bus_ctl_pkg::*;

   logic [SYNC_N-1:0] pin_raw;
   logic [SYNC_N-1:0] sync1_reg;
   logic [SYNC_N-1:0] sync2_reg;
   logic [SYNC_N-1:0] sync3_reg;
   logic [SYNC_N-1:0] pin_reg;
   logic ack;
   logic fault;
   logic halt;
   logic breq;
   logic bgack;
   logic [7:0] ext_cnt_reg;
   logic ext_rst_reg;
   logic [7:0] rout_cnt_reg;
   logic rout_reg;
   bus_state_t bus_reg;
   seq_state_t seq_reg;
   cycle_req_t cyc_reg;
   cycle_req_t issue;
   cycle_rsp_t rsp_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic owner_core_reg;
   logic grant_reg;
   logic can_start;
   logic start;
   logic done_ev;
   logic err_ev;
   logic word_sel_reg;
   logic [4:0] frame_reg;
   logic pending_reg;
   logic resume_reg;
   logic pc_load_reg;
   logic [31:0] ssp_reg;
   logic [31:0] pc_reg;
   logic [31:0] vbr_reg;
   logic [2:0] mask_reg;
   logic [ADDR_W-1:0] vec_base;

   function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] base, input logic low);
      word_addr = low ? base + WORD_STEP : base;
   endfunction

   function automatic logic [31:0] put_half(input logic [31:0] old, input logic low,
                                            input logic [DATA_W-1:0] w);
      put_half = low ? {old[31:16], w} : {w, old[15:0]};
   endfunction

   // Pins are active low; the chain works on active-high copies.
   assign pin_raw = {~bus_grant_ack_n, ~bus_request_n, ~reset_in_n,
                     ~halt_in_n, ~bus_fault_input_n, ~transfer_acknowledge_n};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         pin_reg <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         // A level counts only once two stages agree, which rejects single-cycle glitches.
         pin_reg <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg ^ sync3_reg));
      end
   end

   assign ack = pin_reg[IN_ACK];
   assign fault = pin_reg[IN_FAULT];
   assign halt = pin_reg[IN_HALT];
   assign breq = pin_reg[IN_BREQ];
   assign bgack = pin_reg[IN_BGACK];

   // External reset is honoured only when reset and halt are held together.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_cnt_reg <= 8'h00;
         ext_rst_reg <= 1'b0;
      end else if (pin_reg[IN_RESET] && halt && !rout_reg) begin
         if (ext_cnt_reg < 8'(EXT_RESET_COUNT - 1)) begin
            ext_cnt_reg <= ext_cnt_reg + 8'h01;
         end else begin
            ext_rst_reg <= 1'b1;
         end
      end else begin
         ext_cnt_reg <= 8'h00;
         ext_rst_reg <= 1'b0;
      end
   end

   // The reset instruction pulses the line only; no internal state is touched.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rout_cnt_reg <= 8'h00;
         rout_reg <= 1'b0;
      end else if (reset_instr && !rout_reg) begin
         rout_cnt_reg <= 8'(RESET_OUT_COUNT - 1);
         rout_reg <= 1'b1;
      end else if (rout_cnt_reg != 8'h00) begin
         rout_cnt_reg <= rout_cnt_reg - 8'h01;
      end else begin
         rout_reg <= 1'b0;
      end
   end

   assign vec_base = vbr_reg[ADDR_W-1:0] + BUS_FAULT_INPUT_VEC_OFF;

   always_comb begin
      issue = '0;
      issue.fc = FC_SUPER_DATA;
      case (seq_reg)
         SEQ_RST_SSP: begin
            issue.valid = 1'b1;
            issue.addr = word_addr(SSP_VEC_ADDR, word_sel_reg);
         end
         SEQ_RST_PC: begin
            issue.valid = 1'b1;
            issue.addr = word_addr(PC_VEC_ADDR, word_sel_reg);
         end
         SEQ_STACK: begin
            issue.valid = 1'b1;
            issue.write = 1'b1;
            issue.addr = ssp_reg[ADDR_W-1:0] - WORD_STEP;
            issue.wdata = frame_word;
         end
         SEQ_VEC: begin
            issue.valid = 1'b1;
            issue.addr = word_addr(vec_base, word_sel_reg);
         end
         SEQ_RUN: begin
            issue = core_req;
         end
         default: begin
            issue.valid = 1'b0;
         end
      endcase
   end

   // Halt keeps new cycles from starting; a single step is one released window.
   // The filtered acknowledge lags the pin, so a new cycle waits for it to clear or it would end at once.
   assign can_start = bus_reg == BUS_IDLE && !halt && !ext_rst_reg && !bgack && !grant_reg && !ack;
   assign start = can_start && issue.valid;
   assign core_ready = can_start && seq_reg == SEQ_RUN;
   assign done_ev = bus_reg == BUS_END;
   assign err_ev = bus_reg == BUS_ABORT && !fault;

   // The cycle waits for an answer as long as it takes; timeouts come from outside.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_reg <= BUS_IDLE;
      end else if (ext_rst_reg) begin
         bus_reg <= BUS_IDLE;
      end else begin
         case (bus_reg)
            BUS_IDLE: begin
               if (start) begin
                  bus_reg <= BUS_ADDR;
               end
            end
            BUS_ADDR: begin
               bus_reg <= BUS_WAIT;
            end
            BUS_WAIT: begin
               if (fault && halt && !cyc_reg.rmw) begin
                  bus_reg <= BUS_RERUN;
               end else if (fault) begin
                  bus_reg <= BUS_ABORT;
               end else if (ack) begin
                  bus_reg <= BUS_GRACE;
               end
            end
            BUS_GRACE: begin
               // One spare cycle after the acknowledge catches a late fault.
               if (fault && halt && !cyc_reg.rmw) begin
                  bus_reg <= BUS_RERUN;
               end else if (fault) begin
                  bus_reg <= BUS_ABORT;
               end else begin
                  bus_reg <= BUS_END;
               end
            end
            BUS_ABORT: begin
               if (!fault) begin
                  bus_reg <= BUS_IDLE;
               end
            end
            BUS_RERUN: begin
               // The fault drops first, so waiting for both never misses the release.
               if (!fault && !halt) begin
                  bus_reg <= BUS_ADDR;
               end
            end
            default: begin
               bus_reg <= BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cyc_reg <= '0;
         owner_core_reg <= 1'b0;
      end else if (start) begin
         cyc_reg <= issue;
         owner_core_reg <= seq_reg == SEQ_RUN;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= '0;
      end else if (bus_reg == BUS_WAIT && ack) begin
         rdata_reg <= data_in;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg.done <= done_ev && owner_core_reg;
         rsp_reg.bus_error <= err_ev && owner_core_reg;
         rsp_reg.rdata <= rdata_reg;
      end
   end

   // Grant follows request and acknowledge once the bus is idle with no cycle starting, halted or not.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         grant_reg <= 1'b0;
      end else begin
         grant_reg <= breq && !bgack && (grant_reg || (bus_reg == BUS_IDLE && !start));
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_reg <= SEQ_RST_SSP;
         word_sel_reg <= 1'b0;
         frame_reg <= 5'h00;
         pending_reg <= 1'b1;
         resume_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         ssp_reg <= 32'h00000000;
         pc_reg <= 32'h00000000;
         vbr_reg <= VBR_RESET;
         mask_reg <= MASK_RESET;
      end else if (ext_rst_reg) begin
         // Mask and vector base reload and the sequencer restarts the reset vector fetch; a stop is left by this alone.
         seq_reg <= SEQ_RST_SSP;
         word_sel_reg <= 1'b0;
         pending_reg <= 1'b1;
         pc_load_reg <= 1'b0;
         vbr_reg <= VBR_RESET;
         mask_reg <= MASK_RESET;
      end else begin
         pc_load_reg <= 1'b0;
         if (instr_start && seq_reg == SEQ_RUN) begin
            pending_reg <= 1'b0;
         end
         if (rte_done) begin
            resume_reg <= 1'b0;
         end
         if (err_ev) begin
            // Later assignments win, so an error beats a same-cycle clear.
            if (pending_reg || seq_reg != SEQ_RUN) begin
               seq_reg <= SEQ_DOUBLE;
            end else begin
               pending_reg <= 1'b1;
               seq_reg <= SEQ_STACK;
               frame_reg <= FRAME_LAST;
               resume_reg <= cyc_reg.rmw;
            end
         end else if (done_ev) begin
            case (seq_reg)
               SEQ_RST_SSP: begin
                  ssp_reg <= put_half(ssp_reg, word_sel_reg, rdata_reg);
                  word_sel_reg <= !word_sel_reg;
                  if (word_sel_reg) begin
                     seq_reg <= SEQ_RST_PC;
                  end
               end
               SEQ_RST_PC, SEQ_VEC: begin
                  pc_reg <= put_half(pc_reg, word_sel_reg, rdata_reg);
                  word_sel_reg <= !word_sel_reg;
                  if (word_sel_reg) begin
                     seq_reg <= SEQ_RUN;
                     pc_load_reg <= 1'b1;
                  end
               end
               SEQ_STACK: begin
                  ssp_reg <= ssp_reg - 32'h00000002;
                  if (frame_reg == 5'h00) begin
                     seq_reg <= SEQ_VEC;
                     word_sel_reg <= 1'b0;
                  end else begin
                     frame_reg <= frame_reg - 5'h01;
                  end
               end
               default: begin
                  seq_reg <= seq_reg;
               end
            endcase
         end
      end
   end

   // Address and data float in the abort and repeat states and while halted between cycles.
   assign address_oe = (bus_reg inside {BUS_ADDR, BUS_WAIT, BUS_GRACE, BUS_END}) ||
                       (bus_reg == BUS_IDLE && !halt && !grant_reg && !bgack);
   assign data_oe = cyc_reg.write && (bus_reg inside {BUS_ADDR, BUS_WAIT, BUS_GRACE});
   assign address_strobe_n = !(bus_reg == BUS_WAIT || bus_reg == BUS_GRACE);
   assign read_write = !cyc_reg.write;
   assign function_code = cyc_reg.fc;
   assign address = cyc_reg.addr;
   assign data_out = cyc_reg.wdata;
   assign abort_state_nine = bus_reg == BUS_ABORT && !cyc_reg.rmw_second;
   assign rmw_write_abort_state = bus_reg == BUS_ABORT && cyc_reg.rmw_second;
   assign halt_out_n = 1'b0;
   assign halt_oe = seq_reg == SEQ_DOUBLE;
   assign reset_out_n = 1'b0;
   assign reset_oe = rout_reg;
   assign bus_grant_n = !grant_reg;
   assign frame_index = frame_reg;
   assign core_rsp = rsp_reg;
   assign arch.supervisor_stack_pointer = ssp_reg;
   assign arch.vbr = vbr_reg;
   assign arch.pc = pc_reg;
   assign arch.pc_load = pc_load_reg;
   assign arch.int_mask = mask_reg;
   assign arch.resume_at_read = resume_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || ext_rst_reg);

   sequence s_clean_ack;
      bus_reg == BUS_WAIT && ack && !fault;
   endsequence

   sequence s_late_fault;
      bus_reg == BUS_GRACE && fault && !halt;
   endsequence

   chk_fault_recog: assert property (bus_reg == BUS_WAIT && fault && !halt |=> bus_reg == BUS_ABORT)
      else $error("fault did not abort the cycle");
   chk_delayed_fault: assert property (s_clean_ack ##1 s_late_fault |=> bus_reg == BUS_ABORT)
      else $error("late fault was missed");
   chk_abort_kind: assert property (bus_reg == BUS_ABORT |-> abort_state_nine == !(cyc_reg.rmw && cyc_reg.write))
      else $error("wrong abort state");
   chk_float_fault: assert property (fault && bus_reg inside {BUS_ABORT, BUS_RERUN} |-> !address_oe && !data_oe)
      else $error("bus driven during fault");
   chk_frame_len: assert property ($rose(seq_reg == SEQ_STACK) |-> frame_reg == FRAME_LAST)
      else $error("frame length wrong");
   chk_vector_addr: assert property (seq_reg == SEQ_VEC && !address_strobe_n |->
      address == vbr_reg[23:0] + 24'h8 || address == vbr_reg[23:0] + 24'ha)
      else $error("bad vector address");
   chk_rerun_same: assert property (bus_reg == BUS_RERUN |=> $stable(cyc_reg) && bus_reg inside {BUS_RERUN, BUS_ADDR})
      else $error("repeat cycle changed");
   chk_rmw_no_rerun: assert property (bus_reg == BUS_WAIT && fault && halt && cyc_reg.rmw |=> bus_reg == BUS_ABORT)
      else $error("locked cycle repeated");
   chk_halt_idle: assert property (bus_reg == BUS_IDLE && halt |-> !address_oe ##1 bus_reg == BUS_IDLE)
      else $error("cycle started while halted");
   chk_double_halt: assert property (err_ev && pending_reg |=> seq_reg == SEQ_DOUBLE && halt_oe)
      else $error("double fault not stopped");
   chk_reset_pulse: assert property ($rose(reset_oe) |-> ##123 reset_oe ##1 !reset_oe)
      else $error("reset pulse length wrong");
endmodule // bus_fault_halt_reset_control

// File: sim/bus_far_model.sv
// Far-side model: responder (read data derived from the address) with answer latency, fault and halt injection.
`timescale 1ns/1ps
module bus_far_model (
   // Clock.
   input wire logic clk,
   // Bus pins.
   input wire logic address_strobe_n,
   input wire logic read_write,
   input wire logic [2:0] function_code,
   input wire logic [23:0] address,
   output logic [15:0] data_in = 16'h0,
   output logic ack_n = 1'b1,
   output logic fault_n = 1'b1,
   output logic halt_n = 1'b1,
   // Scenario control and counters.
   input wire logic [2:0] lat,
   input wire logic [1:0] fault_mode,
   input wire logic [31:0] fault_at,
   output logic [31:0] n_cyc = 32'h0,
   output logic [31:0] n_wr = 32'h0,
   output logic [23:0] seen_addr = 24'h0,
   output logic [23:0] prev_addr = 24'h0
);
   logic busy = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [4:0] cnt = 5'h0;
   logic [4:0] t;
   assign t = {2'h0, lat};
   // Changes follow the falling edge so the filters see settled levels.
   always @(negedge clk) begin
      // Released data never repeats the last value.
      if (ack_n) data_in <= ~data_in;
      if (!busy && !address_strobe_n) begin
         busy <= 1'b1;
         cnt <= 5'h0;
         mode <= (n_cyc == fault_at) ? fault_mode : 2'h0;
         n_cyc <= n_cyc + 32'h1;
         prev_addr <= seen_addr;
         seen_addr <= address;
         if (!read_write && function_code == 3'h5) n_wr <= n_wr + 32'h1;
      end else if (busy) begin
         cnt <= cnt + 5'h1;
         if (cnt == t) begin
            ack_n <= mode == 2'h1 || mode == 2'h2;
            fault_n <= !(mode == 2'h1 || mode == 2'h2);
            halt_n <= mode != 2'h2;
            data_in <= address[15:0] ^ 16'ha5c3;
         end
         if (cnt == t + 5'h1 && mode == 2'h3) fault_n <= 1'b0;
         if (cnt == t + 5'h8) fault_n <= 1'b1;
         // Fault goes away two cycles before halt does.
         if (cnt == t + 5'ha) halt_n <= 1'b1;
         if (address_strobe_n) ack_n <= 1'b1;
         if (address_strobe_n && (mode == 2'h0 ? !ack_n : cnt > t + 5'ha)) busy <= 1'b0;
      end
   end
endmodule // bus_far_model

// File: sim/bus_fault_halt_reset_control_test.sv
// Self-checking bench for the bus fault, halt and reset control.
`timescale 1ns/1ps
module bus_fault_halt_reset_control_test;
   import bus_ctl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   cycle_req_t core_req = '0;
   cycle_rsp_t core_rsp;
   arch_state_t arch;
   logic instr_start = 1'b0;
   logic reset_instr = 1'b0;
   logic rte_done = 1'b0;
   logic tb_halt_n = 1'b1;
   logic tb_rst_n = 1'b1;
   logic bus_request_n = 1'b1;
   logic [2:0] lat = 3'h0;
   logic [1:0] fault_mode = 2'h1;
   logic [31:0] fault_at = 32'hffffffff;
   logic [4:0] frame_index;
   logic core_ready, strobe_n, read_write, address_oe, data_oe, ack_n, fault_n, far_halt_n;
   logic halt_out_n, halt_oe, reset_out_n, reset_oe, bus_grant_n, ab9, ab21, be, w;
   logic [2:0] function_code;
   logic [23:0] address, seen_addr, prev_addr, a;
   logic [15:0] data_out, data_in, d, rd;
   logic [31:0] n_cyc, n_wr, s, p;
   logic saw9 = 1'b0;
   logic saw21 = 1'b0;
   int fails = 0;
   int checks_done = 0;
   int seed = 54849;
   int k, i, n, c0;
   wire halt_in_n = tb_halt_n & far_halt_n & (halt_oe ? halt_out_n : 1'b1);
   wire reset_in_n = tb_rst_n & (reset_oe ? reset_out_n : 1'b1);

   bus_fault_halt_reset_control DUT (.clk(clk), .rst(rst), .core_req(core_req), .core_ready(core_ready),
      .core_rsp(core_rsp), .instr_start(instr_start), .reset_instr(reset_instr), .rte_done(rte_done),
      .frame_index(frame_index), .frame_word({11'h0, frame_index}), .arch(arch),
      .address_strobe_n(strobe_n), .read_write(read_write), .function_code(function_code),
      .address(address), .address_oe(address_oe), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in), .transfer_acknowledge_n(ack_n), .bus_fault_input_n(fault_n),
      .halt_in_n(halt_in_n), .halt_out_n(halt_out_n), .halt_oe(halt_oe), .reset_in_n(reset_in_n),
      .reset_out_n(reset_out_n), .reset_oe(reset_oe), .bus_request_n(bus_request_n),
      .bus_grant_ack_n(1'b1), .bus_grant_n(bus_grant_n), .abort_state_nine(ab9),
      .rmw_write_abort_state(ab21));

   bus_far_model far (.clk(clk), .address_strobe_n(strobe_n), .read_write(read_write),
      .function_code(function_code), .address(address), .data_in(data_in), .ack_n(ack_n),
      .fault_n(fault_n), .halt_n(far_halt_n), .lat(lat), .fault_mode(fault_mode), .fault_at(fault_at),
      .n_cyc(n_cyc), .n_wr(n_wr), .seen_addr(seen_addr), .prev_addr(prev_addr));

   initial begin
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] vec(input logic [23:0] x);
      return {x[15:0] ^ 16'ha5c3, (x[15:0] + 16'h2) ^ 16'ha5c3};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic give_up();
      fails++;
      $display("unexpected at %0t: wait ran out", $time);
      stop_test();
   endtask

   // Stacking and vector fetch can take hundreds of cycles, hence the long bound.
   task automatic wait_flag(input int sel);
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         #1;
         if (sel == 0 && arch.pc_load === 1'b1 || sel == 1 && halt_oe === 1'b1) break;
         if (sel == 2 && core_rsp.done === 1'b1 || sel == 2 && core_rsp.bus_error === 1'b1) break;
      end
      if (i == 3000) give_up();
   endtask

   task automatic core_cycle(input logic wr, input logic m, input logic [23:0] x, input logic [15:0] y);
      @(negedge clk);
      core_req = '{1'b1, wr, m, wr & m, 3'h1, x, y};
      #1;
      for (i = 0; i < 900 && core_ready !== 1'b1; i++) @(negedge clk);
      if (i == 900) give_up();
      @(negedge clk);
      core_req.valid = 1'b0;
      wait_flag(2);
      be = core_rsp.bus_error;
      rd = core_rsp.rdata;
   endtask

   task automatic pin_reset();
      @(negedge clk);
      tb_rst_n = 1'b0;
      tb_halt_n = 1'b0;
      repeat (14) @(negedge clk);
      tb_rst_n = 1'b1;
      tb_halt_n = 1'b1;
   endtask

   task automatic boot_check();
      wait_flag(0);
      check(arch.supervisor_stack_pointer, vec(SSP_VEC_ADDR));
      check(arch.pc, vec(PC_VEC_ADDR));
      check({29'h0, arch.int_mask}, {29'h0, MASK_RESET});
      check(arch.vbr, VBR_RESET);
      check({31'h0, halt_oe}, 0);
   endtask

   always @(posedge clk) begin
      #1;
      if (ab9 === 1'b1) saw9 = 1'b1;
      if (ab21 === 1'b1) saw21 = 1'b1;
      if (ab9 === 1'b1 || ab21 === 1'b1) check({30'h0, address_oe, data_oe}, 0);
   end

   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      boot_check();
      for (k = 0; k < 12; k++) begin
         a = 24'($random(seed));
         a[0] = 1'b0;
         d = 16'($random(seed));
         w = 1'($random(seed));
         lat = 3'($random(seed));
         core_cycle(w, 1'b0, a, d);
         check({31'h0, be}, 0);
         if (!w) check({16'h0, rd}, {16'h0, a[15:0] ^ 16'ha5c3});
      end
      // Plain fault, write fault, late fault, then fault with halt on both locked halves.
      for (k = 0; k < 5; k++) begin
         @(negedge clk) instr_start = 1'b1;
         @(negedge clk) instr_start = 1'b0;
         fault_mode = k < 2 ? 2'h1 : (k == 2 ? 2'h3 : 2'h2);
         fault_at = n_cyc;
         saw9 = 1'b0;
         saw21 = 1'b0;
         s = n_wr;
         core_cycle(k[0], k > 2, 24'h001230, 16'h5aa5);
         check({31'h0, be}, 1);
         check({30'h0, saw9, saw21}, {30'h0, !(k[0] && k > 2), k[0] && k > 2});
         wait_flag(0);
         check(arch.pc, vec(BUS_FAULT_INPUT_VEC_OFF));
         check(n_wr - s, 26);
         check({31'h0, arch.resume_at_read}, k > 2);
         @(negedge clk) rte_done = 1'b1;
         @(negedge clk) rte_done = 1'b0;
         #1;
         check({31'h0, arch.resume_at_read}, 0);
      end
      // Re-runs straight after an exception must not count as a second fault.
      for (k = 0; k < 2; k++) begin
         fault_mode = 2'h2;
         fault_at = n_cyc;
         c0 = n_cyc;
         core_cycle(1'b1, 1'b0, 24'h00abc4, 16'h1234);
         check({31'h0, be}, 0);
         check(n_cyc - c0, 2);
         check({seen_addr, 5'h0, function_code}, {24'h00abc4, 8'h1});
         check({prev_addr, 8'h0}, {24'h00abc4, 8'h0});
         check({16'h0, data_out}, {16'h0, 16'h1234});
         check({31'h0, halt_oe}, 0);
      end
      @(negedge clk) instr_start = 1'b1;
      @(negedge clk) instr_start = 1'b0;
      fault_mode = 2'h1;
      fault_at = n_cyc;
      core_cycle(1'b0, 1'b0, 24'h000100, 16'h0);
      fault_at = n_cyc + 2;
      wait_flag(1);
      check({31'h0, halt_out_n}, 0);
      fault_at = n_cyc + 1;
      pin_reset();
      wait_flag(1);
      fault_at = 32'hffffffff;
      pin_reset();
      boot_check();
      s = arch.supervisor_stack_pointer;
      p = arch.pc;
      n = 0;
      @(negedge clk) reset_instr = 1'b1;
      repeat (200) begin
         @(negedge clk);
         reset_instr = 1'b0;
         if (reset_oe === 1'b1) n++;
      end
      check(n, RESET_OUT_CYCLES);
      check({31'h0, reset_out_n}, 0);
      check(arch.supervisor_stack_pointer ^ arch.pc, s ^ p);
      @(negedge clk) tb_halt_n = 1'b0;
      repeat (8) @(negedge clk);
      bus_request_n = 1'b0;
      for (i = 0; i < 60 && bus_grant_n !== 1'b0; i++) @(negedge clk);
      check({31'h0, bus_grant_n}, 0);
      bus_request_n = 1'b1;
      core_req = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h1, 24'h000040, 16'h0};
      n = 0;
      repeat (20) @(negedge clk) n += (core_ready !== 1'b0 || strobe_n !== 1'b1) ? 1 : 0;
      check(n, 0);
      // One released window lets exactly one cycle out, and that cycle still finishes under halt.
      c0 = n_cyc;
      tb_halt_n = 1'b1;
      for (i = 0; i < 60 && strobe_n !== 1'b0; i++) @(negedge clk);
      tb_halt_n = 1'b0;
      core_req.valid = 1'b0;
      wait_flag(2);
      rd = core_rsp.rdata;
      repeat (20) @(negedge clk);
      check(n_cyc - c0, 1);
      check({16'h0, rd}, {16'h0, 16'h0040 ^ 16'ha5c3});
      tb_halt_n = 1'b1;
      core_cycle(1'b0, 1'b0, 24'h000044, 16'h0);
      check({15'h0, be, rd}, {16'h0, 16'h0044 ^ 16'ha5c3});
      stop_test();
   end
endmodule // bus_fault_halt_reset_control_test
